/* verilog/eas_pkg.sv */
/*
 * Shared types and constants of the effective address and segment select block.
 * Assumes a decoder and register file on the same clock that supply decoded fields.
 */
`default_nettype none
package eas_pkg;

   // ****************************************************************
   // Widths, register numbers and masks.
   // ****************************************************************
   localparam int EAS_ADDR_W = 64;
   localparam int EAS_SEL_W = 16;
   localparam int EAS_DISP_W = 32;
   localparam int EAS_FAR_W = 48;
   localparam int EAS_FAR_OFF_LSB = 0;
   localparam int EAS_FAR_OFF_W = 32;
   localparam int EAS_FAR_SEL_LSB = 32;
   localparam int EAS_NUM_SEGS = 6;
   localparam logic [3:0] EAS_GPR_STACK_PTR = 4'h4;
   localparam logic [3:0] EAS_GPR_FRAME_PTR = 4'h5;
   localparam logic [63:0] EAS_MASK16 = 64'h0000_0000_0000_FFFF;
   localparam logic [63:0] EAS_MASK32 = 64'h0000_0000_FFFF_FFFF;
   localparam logic [63:0] EAS_MASK64 = 64'hFFFF_FFFF_FFFF_FFFF;
   localparam logic [63:0] EAS_ZERO64 = 64'h0000_0000_0000_0000;

   // ****************************************************************
   // Enumerations.
   // ****************************************************************
   typedef enum logic [2:0] {eas_seg_extra, eas_seg_code, eas_seg_stack, eas_seg_data,
                             eas_seg_thr_a, eas_seg_thr_b} eas_seg_t;
   typedef enum logic [2:0] {eas_ref_fetch, eas_ref_push_pop, eas_ref_data, eas_ref_str_dst,
                             eas_ref_far_ptr, eas_ref_sel_load} eas_kind_t;
   typedef enum logic [1:0] {eas_mode_legacy, eas_mode_compat, eas_mode_long} eas_mode_t;
   typedef enum logic [1:0] {eas_asz_16, eas_asz_32, eas_asz_64} eas_asize_t;
   typedef enum logic [1:0] {eas_scl_1, eas_scl_2, eas_scl_4, eas_scl_8} eas_scale_t;
   typedef enum logic [1:0] {eas_dsp_none, eas_dsp_8, eas_dsp_16, eas_dsp_32} eas_dsize_t;

   // ****************************************************************
   // Carriers.
   // ****************************************************************
   typedef struct packed {
      logic valid;
      eas_kind_t kind;
      eas_mode_t mode;
      eas_asize_t asize;
      logic width_bit;
      logic ovr_valid;
      eas_seg_t ovr_seg;
      logic base_valid;
      logic [3:0] base_num;
      logic [63:0] base_val;
      logic idx_valid;
      logic [3:0] idx_num;
      logic [63:0] idx_val;
      eas_scale_t scale;
      eas_dsize_t disp_size;
      logic [31:0] disp;
      logic rip_rel;
      logic [63:0] next_ip;
      logic [47:0] far_mem;
      logic sel_from_reg;
      logic [15:0] sel_reg;
      logic [15:0] sel_mem;
   } eas_req_t;

   typedef struct packed {
      logic valid;
      eas_seg_t seg;
      logic [63:0] eff_addr;
      logic [63:0] lin_addr;
      logic [31:0] far_offset;
      logic [15:0] selector;
      logic sel_valid;
   } eas_resp_t;

endpackage : eas_pkg
`default_nettype wire

/* verilog/eas_core.sv */
/*
 * Effective address generation and segment register selection, one pipeline stage.
 * Assumes the decoder, register file and segment bases are on ref_clk and stable with valid.
 */
// Overview of operation
// - Outside 64-bit mode offsets are 32 or 16 bits with a selector.
// - In 64-bit mode offsets are 32 or 64 bits; 16-bit address size is taken as 32.
// - Instruction fetches always use the code segment, override ignored.
// - Push and pop always use the stack segment, override ignored.
// - Stack or frame pointer base defaults to the stack segment.
// - Other data references default to the data segment.
// - String destinations always use the extra segment, never overridden.
// - An override prefix replaces the default segment for data operands.
// - Explicit selectors come from memory or from a 16-bit register.
// - Far pointer: offset from first doubleword, selector from next word.
// - Compatibility mode segments exactly as legacy protected mode.
// - In 64-bit mode code, data, extra and stack bases are zero.
// - In 64-bit mode the two thread base segments still add bases.
// - Displacement is 8, 16 or 32 bits taken from the instruction.
// - Scale 2, 4 or 8 multiplies the index before the sum.
// - Address is sign-extended displacement plus zero-extended base plus scaled zero-extended index.
// - The stack pointer is never used as an index.
// - Any component may be absent; scale applies only with an index.
// - In 64-bit mode base and index are 32 bits, 64 with width bit.
// - In 64-bit mode base and index come from sixteen registers.
// - In 64-bit mode pointer-relative adds sign-extended 32-bit displacement to next instruction.
// - 16-bit address size limits offsets and displacements to 16 bits.
`timescale 1ns/10ps
`default_nettype none
module eas_core
   import eas_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire eas_req_t req,
   input wire logic [EAS_NUM_SEGS-1:0][63:0] seg_base,
   output eas_resp_t resp
);

   // ****************************************************************
   // Helper functions.
   // ****************************************************************
   // Keeps the low 16, 32 or 64 bits of a value.
   function automatic logic [63:0] eas_trim(input logic [63:0] val, input eas_asize_t sz);
      logic [63:0] res;
      res = val;
      case (sz)
         eas_asz_16: res = val & EAS_MASK16;
         eas_asz_32: res = val & EAS_MASK32;
         default: res = val;
      endcase
      return res;
   endfunction : eas_trim

   // Sign-extends a 32-bit value to 64 bits.
   function automatic logic [63:0] eas_sext32(input logic [31:0] val);
      return {{32{val[31]}}, val};
   endfunction : eas_sext32

   // Sign-extends the displacement field by its encoded size.
   function automatic logic [63:0] eas_disp_ext(input logic [31:0] d, input eas_dsize_t ds);
      logic [63:0] res;
      res = EAS_ZERO64;
      case (ds)
         eas_dsp_8: res = {{56{d[7]}}, d[7:0]};
         eas_dsp_16: res = {{48{d[15]}}, d[15:0]};
         eas_dsp_32: res = eas_sext32(d);
         default: res = EAS_ZERO64;
      endcase
      return res;
   endfunction : eas_disp_ext

   // ****************************************************************
   // State and next-state logic.
   // ****************************************************************
   typedef struct packed {
      eas_resp_t out;
   } eas_state_t;

   eas_state_t state;
   eas_state_t next_state;
   eas_asize_t eff_asize;
   eas_asize_t reg_size;
   logic idx_used;
   logic [63:0] base_term;
   logic [63:0] idx_term;
   logic [63:0] disp_term;
   logic [63:0] offset;
   logic [63:0] sel_base;
   eas_seg_t seg_sel;

   always_comb
   begin
      next_state = state;
      next_state.out.valid = req.valid;
      // Address size: 16-bit not available in 64-bit mode, 64-bit only there.
      eff_asize = req.asize;
      if (req.mode == eas_mode_long)
      begin
         if (req.asize == eas_asz_16)
         begin
            eff_asize = eas_asz_32;
         end
      end
      else if (req.asize == eas_asz_64)
      begin
         eff_asize = eas_asz_32;
      end
      // Register read width for base and index.
      reg_size = eff_asize;
      if (req.mode == eas_mode_long)
      begin
         reg_size = req.width_bit ? eas_asz_64 : eas_asz_32;
      end
      idx_used = req.idx_valid && (req.idx_num != EAS_GPR_STACK_PTR);
      base_term = req.base_valid ? eas_trim(req.base_val, reg_size) : EAS_ZERO64;
      idx_term = EAS_ZERO64;
      if (idx_used)
      begin
         idx_term = eas_trim(req.idx_val, reg_size) << req.scale;
      end
      disp_term = eas_disp_ext(req.disp, req.disp_size);
      if (eff_asize == eas_asz_16)
      begin
         disp_term = disp_term & EAS_MASK16;
      end
      // Effective address.
      offset = eas_trim(disp_term + base_term + idx_term, eff_asize);
      if (req.mode == eas_mode_long && req.rip_rel)
      begin
         offset = req.next_ip + eas_sext32(req.disp);
      end
      if (req.kind == eas_ref_fetch)
      begin
         offset = eas_trim(req.next_ip, eff_asize);
      end
      // Segment choice.
      case (req.kind)
         eas_ref_fetch: seg_sel = eas_seg_code;
         eas_ref_push_pop: seg_sel = eas_seg_stack;
         eas_ref_str_dst: seg_sel = eas_seg_extra;
         default:
         begin
            if (req.ovr_valid)
            begin
               seg_sel = req.ovr_seg;
            end
            else if (req.base_valid && (req.base_num == EAS_GPR_STACK_PTR ||
                                        req.base_num == EAS_GPR_FRAME_PTR))
            begin
               seg_sel = eas_seg_stack;
            end
            else
            begin
               seg_sel = eas_seg_data;
            end
         end
      endcase
      // Segment base applied to the linear address.
      sel_base = seg_base[seg_sel];
      if (req.mode == eas_mode_long && seg_sel != eas_seg_thr_a && seg_sel != eas_seg_thr_b)
      begin
         sel_base = EAS_ZERO64;
      end
      next_state.out.seg = seg_sel;
      next_state.out.eff_addr = offset;
      if (req.mode == eas_mode_long)
      begin
         next_state.out.lin_addr = sel_base + offset;
      end
      else
      begin
         next_state.out.lin_addr = (sel_base + offset) & EAS_MASK32;
      end
      // Explicit selectors and far pointers.
      next_state.out.sel_valid = 1'b0;
      next_state.out.far_offset = state.out.far_offset;
      next_state.out.selector = state.out.selector;
      if (req.valid && req.kind == eas_ref_far_ptr)
      begin
         next_state.out.far_offset = req.far_mem[EAS_FAR_OFF_LSB +: EAS_FAR_OFF_W];
         next_state.out.selector = req.far_mem[EAS_FAR_SEL_LSB +: EAS_SEL_W];
         next_state.out.sel_valid = 1'b1;
      end
      else if (req.valid && req.kind == eas_ref_sel_load)
      begin
         next_state.out.selector = req.sel_from_reg ? req.sel_reg : req.sel_mem;
         next_state.out.sel_valid = 1'b1;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign resp = state.out;

   // ****************************************************************
   // Checks.
   // ****************************************************************
   AST_FETCH_CODE: assert property (@(posedge ref_clk) disable iff (rst)
      req.valid && req.kind == eas_ref_fetch |=> resp.valid && resp.seg == eas_seg_code)
      else $error("fetch not on code segment");

   AST_PUSH_STACK: assert property (@(posedge ref_clk) disable iff (rst)
      req.valid && req.kind == eas_ref_push_pop && req.ovr_valid |=> resp.seg == eas_seg_stack)
      else $error("push or pop left stack segment");

   AST_STR_EXTRA: assert property (@(posedge ref_clk) disable iff (rst)
      req.valid && req.kind == eas_ref_str_dst |=> resp.seg == eas_seg_extra)
      else $error("string destination not on extra segment");

   AST_OVERRIDE: assert property (@(posedge ref_clk) disable iff (rst)
      req.valid && req.kind == eas_ref_data && req.ovr_valid |=> resp.seg == $past(req.ovr_seg))
      else $error("override not applied");

   AST_STACK_BASE: assert property (@(posedge ref_clk) disable iff (rst)
      req.valid && req.kind == eas_ref_data && !req.ovr_valid && req.base_valid &&
      req.base_num == EAS_GPR_FRAME_PTR |=> resp.seg == eas_seg_stack)
      else $error("frame pointer base not on stack segment");

   AST_DATA_DEFAULT: assert property (@(posedge ref_clk) disable iff (rst)
      req.valid && req.kind == eas_ref_data && !req.ovr_valid && !req.base_valid
      |=> resp.seg == eas_seg_data)
      else $error("data default segment wrong");

   AST_FLAT_BASE: assert property (@(posedge ref_clk) disable iff (rst)
      req.valid && req.mode == eas_mode_long && req.kind == eas_ref_data && !req.ovr_valid
      |=> resp.lin_addr == resp.eff_addr)
      else $error("flat segment base not zero");

   AST_THR_BASE: assert property (@(posedge ref_clk) disable iff (rst)
      req.valid && req.mode == eas_mode_long && req.kind == eas_ref_data && req.ovr_valid &&
      req.ovr_seg == eas_seg_thr_b |=> resp.lin_addr == $past(seg_base[5]) + resp.eff_addr)
      else $error("thread base not added");

   AST_NO_SP_INDEX: assert property (@(posedge ref_clk) disable iff (rst)
      req.valid && req.kind == eas_ref_data && !req.base_valid && !req.rip_rel &&
      req.disp_size == eas_dsp_none && req.idx_valid && req.idx_num == EAS_GPR_STACK_PTR
      |=> resp.eff_addr == EAS_ZERO64)
      else $error("stack pointer used as index");

   AST_RIP_REL: assert property (@(posedge ref_clk) disable iff (rst)
      req.valid && req.kind == eas_ref_data && req.mode == eas_mode_long && req.rip_rel
      |=> resp.eff_addr == $past(req.next_ip) + {{32{$past(req.disp[31])}}, $past(req.disp)})
      else $error("pointer-relative address wrong");

   AST_ADDR16: assert property (@(posedge ref_clk) disable iff (rst)
      req.valid && req.mode != eas_mode_long && req.asize == eas_asz_16
      |=> resp.eff_addr[63:16] == 48'h0000_0000_0000)
      else $error("16-bit offset exceeds 16 bits");

   AST_LEGACY_LIN: assert property (@(posedge ref_clk) disable iff (rst)
      req.valid && req.mode == eas_mode_legacy && req.kind == eas_ref_str_dst
      |=> resp.lin_addr == (($past(seg_base[0]) + resp.eff_addr) & EAS_MASK32))
      else $error("legacy linear address wrong");

   AST_FAR_PTR: assert property (@(posedge ref_clk) disable iff (rst)
      req.valid && req.kind == eas_ref_far_ptr |=> resp.sel_valid &&
      resp.far_offset == $past(req.far_mem[31:0]) && resp.selector == $past(req.far_mem[47:32]))
      else $error("far pointer split wrong");

   AST_SEL_SRC: assert property (@(posedge ref_clk) disable iff (rst)
      req.valid && req.kind == eas_ref_sel_load && req.sel_from_reg
      |=> resp.sel_valid && resp.selector == $past(req.sel_reg))
      else $error("register selector not taken");

   AST_SCALE: assert property (@(posedge ref_clk) disable iff (rst)
      req.valid && req.kind == eas_ref_data && req.mode == eas_mode_long && req.width_bit &&
      req.asize == eas_asz_64 && !req.rip_rel && !req.base_valid &&
      req.disp_size == eas_dsp_none && req.idx_valid && req.idx_num == 4'h1 &&
      req.scale == eas_scl_8 |=> resp.eff_addr == ($past(req.idx_val) << 3))
      else $error("scaled index wrong");

endmodule : eas_core
`default_nettype wire

/* tb/eas_dec_model.sv */
/*
 * Decoder side model: presents requests and segment bases to the block.
 * Assumes its tasks are called by the bench on the block's clock.
 */
`timescale 1ns/10ps
`default_nettype none
module eas_dec_model
   import eas_pkg::*;
(
   input wire logic ref_clk,
   output logic [EAS_NUM_SEGS-1:0][63:0] seg_base,
   output eas_req_t req
);
   // ****************************************************************
   // Drivers: requests changed just after a rising edge, segment bases at once.
   // ****************************************************************
   initial
   begin
      req = '0;
   end
   task automatic put(input eas_req_t r);
      @(posedge ref_clk);
      #1;
      req = r;
   endtask : put
   task automatic set_base(input int k, input logic [63:0] v);
      seg_base[k] = v;
   endtask : set_base
endmodule : eas_dec_model
`default_nettype wire

/* tb/testbench.sv */
/*
 * Self-checking bench of the address and segment block with a decoder model.
 * Assumes a one-cycle answer latency and a synchronous active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import eas_pkg::*;
   logic ref_clk;
   logic rst;
   eas_req_t req;
   logic [EAS_NUM_SEGS-1:0][63:0] seg_base;
   eas_resp_t resp;
   eas_resp_t exp_q[$];
   eas_resp_t e;
   logic [31:0] last_far;
   int err_total;
   int checks_done;
   eas_dec_model u_dec (.ref_clk(ref_clk), .seg_base(seg_base), .req(req));
   eas_core dut (.ref_clk(ref_clk), .rst(rst), .req(req), .seg_base(seg_base), .resp(resp));
   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   // ****************************************************************
   // Expected answer worked out from the request.
   // ****************************************************************
   function automatic logic [63:0] msk(input int w);
      return (w == 64) ? EAS_MASK64 : (w == 32) ? EAS_MASK32 : EAS_MASK16;
   endfunction : msk
   function automatic eas_resp_t exp_of(input eas_req_t r, input logic [5:0][63:0] sb);
      eas_resp_t x;
      logic lm;
      int aw;
      int rw;
      logic [63:0] b;
      logic [63:0] i;
      logic [63:0] d;
      x = '0;
      x.valid = 1'b1;
      lm = (r.mode == eas_mode_long);
      aw = (r.asize == eas_asz_16 && !lm) ? 16 : (r.asize == eas_asz_64 && lm) ? 64 : 32;
      rw = lm ? (r.width_bit ? 64 : 32) : aw;
      b = r.base_valid ? r.base_val & msk(rw) : EAS_ZERO64;
      i = EAS_ZERO64;
      if (r.idx_valid && r.idx_num != EAS_GPR_STACK_PTR) i = (r.idx_val & msk(rw)) << r.scale;
      case (r.disp_size)
         eas_dsp_8: d = {{56{r.disp[7]}}, r.disp[7:0]};
         eas_dsp_16: d = {{48{r.disp[15]}}, r.disp[15:0]};
         eas_dsp_32: d = {{32{r.disp[31]}}, r.disp};
         default: d = EAS_ZERO64;
      endcase
      if (aw == 16) d = d & EAS_MASK16;
      x.eff_addr = (d + b + i) & msk(aw);
      if (r.rip_rel && lm) x.eff_addr = r.next_ip + {{32{r.disp[31]}}, r.disp};
      if (r.kind == eas_ref_fetch) x.eff_addr = r.next_ip & msk(aw);
      case (r.kind)
         eas_ref_fetch: x.seg = eas_seg_code;
         eas_ref_push_pop: x.seg = eas_seg_stack;
         eas_ref_str_dst: x.seg = eas_seg_extra;
         default: x.seg = r.ovr_valid ? r.ovr_seg : eas_seg_data;
      endcase
      if (r.kind inside {eas_ref_data, eas_ref_far_ptr, eas_ref_sel_load} && !r.ovr_valid
          && r.base_valid && r.base_num inside {EAS_GPR_STACK_PTR, EAS_GPR_FRAME_PTR})
         x.seg = eas_seg_stack;
      if (!lm) x.lin_addr = (sb[x.seg] + x.eff_addr) & EAS_MASK32;
      else if (x.seg inside {eas_seg_thr_a, eas_seg_thr_b}) x.lin_addr = sb[x.seg] + x.eff_addr;
      else x.lin_addr = x.eff_addr;
      x.sel_valid = r.kind inside {eas_ref_far_ptr, eas_ref_sel_load};
      x.far_offset = last_far;
      x.selector = r.sel_from_reg ? r.sel_reg : r.sel_mem;
      if (r.kind == eas_ref_far_ptr) x.selector = r.far_mem[47:32];
      return x;
   endfunction : exp_of
   // ****************************************************************
   // Stimulus and comparison tasks.
   // ****************************************************************
   function automatic eas_req_t rnd_req();
      eas_req_t r;
      for (int k = 0; k < $bits(r); k++) r[k] = 1'($urandom % 2);
      r.valid = 1'b1;
      r.kind = eas_kind_t'($urandom % 6);
      r.mode = eas_mode_t'($urandom % 3);
      r.asize = eas_asize_t'($urandom % 3);
      r.ovr_seg = eas_seg_t'($urandom % 6);
      if ($urandom % 3 == 0) r.base_num = {3'b010, r.base_num[0]};
      if ($urandom % 4 == 0) r.idx_num = EAS_GPR_STACK_PTR;
      r.rip_rel = ($urandom % 4 == 0) && (r.kind != eas_ref_fetch);
      return r;
   endfunction : rnd_req
   task automatic send(input eas_req_t r);
      if (r.valid && r.kind == eas_ref_far_ptr) last_far = r.far_mem[31:0];
      u_dec.put(r);
      if (r.valid) exp_q.push_back(exp_of(r, seg_base));
   endtask : send
   task automatic chk(input logic ok, input string what);
      checks_done++;
      if (ok !== 1'b1)
      begin
         err_total++;
         $display("[ERR] %0t %s mismatch", $time, what);
      end
   endtask : chk
   task automatic drain(input string name);
      eas_req_t r;
      r = rnd_req();
      r.valid = 1'b0;
      send(r);
      repeat (3) @(posedge ref_clk);
      chk(exp_q.size() == 0, "missing answer");
      $display("test %s done, errors %0d", name, err_total);
   endtask : drain
   task automatic tally_and_finish();
      $display("checks %0d, errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish
   // ****************************************************************
   // Answer monitor.
   // ****************************************************************
   always @(negedge ref_clk)
   begin
      if (rst === 1'b0 && resp.valid === 1'b1)
      begin
         chk(exp_q.size() != 0, "unexpected answer");
         if (exp_q.size() != 0)
         begin
            e = exp_q.pop_front();
            chk(resp.seg === e.seg, "segment");
            if (!e.sel_valid) chk(resp.eff_addr === e.eff_addr, "offset");
            if (!e.sel_valid) chk(resp.lin_addr === e.lin_addr, "linear");
            chk(resp.sel_valid === e.sel_valid, "selector flag");
            if (e.sel_valid) chk(resp.selector === e.selector, "selector");
            if (e.sel_valid) chk(resp.far_offset === e.far_offset, "far offset");
         end
      end
   end
   // ****************************************************************
   // Main sequence and watchdog.
   // ****************************************************************
   initial
   begin
      eas_req_t r;
      err_total = 0;
      checks_done = 0;
      last_far = '0;
      rst = 1'b1;
      void'($urandom(8102));
      for (int k = 0; k < EAS_NUM_SEGS; k++) u_dec.set_base(k, {$urandom, $urandom});
      repeat (5) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      r = rnd_req();
      r.kind = eas_ref_data;
      r.mode = eas_mode_long;
      r.ovr_valid = 1'b0;
      r.rip_rel = 1'b0;
      r.base_valid = 1'b1;
      r.base_num = EAS_GPR_FRAME_PTR;
      r.idx_valid = 1'b0;
      r.disp_size = eas_dsp_8;
      r.disp = 32'h0000_0080;
      send(r);
      r.base_valid = 1'b0;
      r.disp_size = eas_dsp_none;
      r.idx_valid = 1'b1;
      r.idx_num = EAS_GPR_STACK_PTR;
      send(r);
      r.width_bit = 1'b1;
      r.asize = eas_asz_64;
      r.idx_num = 4'h1;
      r.scale = eas_scl_8;
      send(r);
      drain("walk");
      for (int n = 0; n < 400; n++)
      begin
         r = rnd_req();
         r.valid = ($urandom % 8 != 0);
         send(r);
      end
      drain("random");
      repeat (5) send(rnd_req());
      @(posedge ref_clk);
      #1;
      rst = 1'b1;
      r = rnd_req();
      r.valid = 1'b0;
      u_dec.put(r);
      @(posedge ref_clk);
      #1;
      exp_q.delete();
      last_far = '0;
      chk(resp === '0, "reset answer");
      rst = 1'b0;
      repeat (40) send(rnd_req());
      drain("reset");
      tally_and_finish();
   end
   initial
   begin
      #20000;
      err_total++;
      $display("[ERR] %0t watchdog expired", $time);
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
